// >>> tcw_pkg.sv
package tcw_pkg;

   // ---------------------------------------------------------------
   // Waveform modes
   // ---------------------------------------------------------------
   localparam logic [1:0] WAVE_NORMAL    = 2'h0;
   localparam logic [1:0] WAVE_PHASE_PWM = 2'h1;
   localparam logic [1:0] WAVE_CLEAR     = 2'h2;
   localparam logic [1:0] WAVE_FAST_PWM  = 2'h3;

   // ---------------------------------------------------------------
   // Compare output actions
   // ---------------------------------------------------------------
   localparam logic [1:0] OUT_NONE   = 2'h0;
   localparam logic [1:0] OUT_TOGGLE = 2'h1;
   localparam logic [1:0] OUT_CLEAR  = 2'h2;
   localparam logic [1:0] OUT_SET    = 2'h3;

   // ---------------------------------------------------------------
   // Counter limits and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] COUNT_BOTTOM  = 8'h00;
   localparam logic [7:0] COUNT_MAX     = 8'hFF;
   localparam logic [7:0] COUNT_RESET   = 8'h00;
   localparam logic [7:0] COMPARE_RESET = 8'h00;
   localparam logic       OUTPUT_RESET  = 1'b0;

   // ---------------------------------------------------------------
   // Prescale selections and divide masks (tick when low bits all set)
   // ---------------------------------------------------------------
   localparam logic [2:0] PRESC_STOP  = 3'h0;
   localparam logic [2:0] PRESC_1     = 3'h1;
   localparam logic [2:0] PRESC_8     = 3'h2;
   localparam logic [2:0] PRESC_64    = 3'h3;
   localparam logic [2:0] PRESC_256   = 3'h4;
   localparam logic [2:0] PRESC_1024  = 3'h5;
   localparam int         PRESC_BITS  = 10;
   localparam logic [9:0] MASK_8      = 10'h007;
   localparam logic [9:0] MASK_64     = 10'h03F;
   localparam logic [9:0] MASK_256    = 10'h0FF;
   localparam logic [9:0] MASK_1024   = 10'h3FF;

endpackage

// >>> tcw_timer8.sv
`timescale 1ns/1ps
module tcw_timer8 #(
   parameter int PRESC_WIDTH = tcw_pkg::PRESC_BITS
) (
   input  wire logic       clock,
   input  wire logic       rstn,
   input  wire logic [1:0] waveform_mode,
   input  wire logic [1:0] compare_output_mode,
   input  wire logic [2:0] prescale_select,
   input  wire logic       force_compare_strobe,
   input  wire logic       counter_write,
   input  wire logic [7:0] counter_write_data,
   input  wire logic       compare_write,
   input  wire logic [7:0] compare_write_data,
   input  wire logic       overflow_flag_clear,
   input  wire logic       overflow_int_ack,
   input  wire logic       compare_flag_clear,
   input  wire logic       compare_int_ack,
   input  wire logic       port_latch,
   input  wire logic       compare_pin_direction,
   output logic            pin_out,
   output logic            pin_oe,
   output logic            compare_output,
   output logic [7:0]      counter_value,
   output logic [7:0]      compare_value,
   output logic [7:0]      compare_buffer,
   output logic            overflow_flag,
   output logic            compare_flag
);

   // ---------------------------------------------------------------
   // Elaboration check
   // ---------------------------------------------------------------
   if (PRESC_WIDTH != tcw_pkg::PRESC_BITS) begin : g_bad_width
      $error("prescaler width must match the divide masks");
   end

   // ---------------------------------------------------------------
   // Prescaler
   // ---------------------------------------------------------------
   logic [PRESC_WIDTH-1:0] presc_reg;
   logic                   timer_tick;

   // Divider never restarts, so a new selection may shorten the first tick
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         presc_reg <= '0;
      end else begin
         presc_reg <= presc_reg + 1'b1;
      end
   end

   always_comb begin
      case (prescale_select)
         tcw_pkg::PRESC_1:    timer_tick = 1'b1;
         tcw_pkg::PRESC_8:    timer_tick = (presc_reg & tcw_pkg::MASK_8) == tcw_pkg::MASK_8;
         tcw_pkg::PRESC_64:   timer_tick = (presc_reg & tcw_pkg::MASK_64) == tcw_pkg::MASK_64;
         tcw_pkg::PRESC_256:  timer_tick = (presc_reg & tcw_pkg::MASK_256) == tcw_pkg::MASK_256;
         tcw_pkg::PRESC_1024: timer_tick = presc_reg == tcw_pkg::MASK_1024;
         default:             timer_tick = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // Mode decode
   // ---------------------------------------------------------------
   function automatic logic is_pwm(input logic [1:0] mode);
      is_pwm = (mode == tcw_pkg::WAVE_FAST_PWM) || (mode == tcw_pkg::WAVE_PHASE_PWM);
   endfunction

   logic       block_reg;
   logic       match;
   logic       at_max;
   logic       wrap_pwm;
   logic [7:0] counter_next;

   // Blocking survives a stopped timer until the next real tick
   assign match    = (counter_value == compare_value) && !block_reg;
   assign at_max   = counter_value == tcw_pkg::COUNT_MAX;
   assign wrap_pwm = timer_tick && at_max && !counter_write
                     && waveform_mode == tcw_pkg::WAVE_FAST_PWM;

   // ---------------------------------------------------------------
   // Counter
   // ---------------------------------------------------------------
   always_comb begin
      counter_next = counter_value + 8'h01;
      if (waveform_mode == tcw_pkg::WAVE_CLEAR && match) begin
         counter_next = tcw_pkg::COUNT_BOTTOM;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         counter_value <= tcw_pkg::COUNT_RESET;
      end else if (counter_write) begin
         counter_value <= counter_write_data;
      end else if (timer_tick) begin
         counter_value <= counter_next;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         block_reg <= 1'b0;
      end else if (counter_write) begin
         block_reg <= 1'b1;
      end else if (timer_tick) begin
         block_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Compare value and its buffer
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         compare_buffer <= tcw_pkg::COMPARE_RESET;
      end else if (compare_write) begin
         compare_buffer <= compare_write_data;
      end
   end

   // Reload at top keeps fast PWM pulses whole; a write landing with the reload wins
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         compare_value <= tcw_pkg::COMPARE_RESET;
      end else if (!is_pwm(waveform_mode) && compare_write) begin
         compare_value <= compare_write_data;
      end else if (wrap_pwm) begin
         compare_value <= compare_write ? compare_write_data : compare_buffer;
      end
   end

   // ---------------------------------------------------------------
   // Flags: a set in the same cycle as a clear wins
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         overflow_flag <= 1'b0;
      end else if (timer_tick && at_max && !counter_write) begin
         overflow_flag <= 1'b1;
      end else if (overflow_flag_clear || overflow_int_ack) begin
         overflow_flag <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         compare_flag <= 1'b0;
      end else if (timer_tick && match) begin
         compare_flag <= 1'b1;
      end else if (compare_flag_clear || compare_int_ack) begin
         compare_flag <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Compare output register
   // ---------------------------------------------------------------
   logic match_act;
   logic force_act;

   assign match_act = timer_tick && match;
   assign force_act = force_compare_strobe && !is_pwm(waveform_mode);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         compare_output <= tcw_pkg::OUTPUT_RESET;
      end else if (waveform_mode == tcw_pkg::WAVE_FAST_PWM) begin
         // Bottom outranks match so compare at max holds a steady level
         if (wrap_pwm && compare_output_mode == tcw_pkg::OUT_CLEAR) begin
            compare_output <= 1'b1;
         end else if (wrap_pwm && compare_output_mode == tcw_pkg::OUT_SET) begin
            compare_output <= 1'b0;
         end else if (match_act) begin
            case (compare_output_mode)
               tcw_pkg::OUT_TOGGLE: compare_output <= !compare_output;
               tcw_pkg::OUT_CLEAR:  compare_output <= 1'b0;
               tcw_pkg::OUT_SET:    compare_output <= 1'b1;
               default:             compare_output <= compare_output;
            endcase
         end
      end else if (waveform_mode != tcw_pkg::WAVE_PHASE_PWM && (match_act || force_act)) begin
         case (compare_output_mode)
            tcw_pkg::OUT_TOGGLE: compare_output <= !compare_output;
            tcw_pkg::OUT_CLEAR:  compare_output <= 1'b0;
            tcw_pkg::OUT_SET:    compare_output <= 1'b1;
            default:             compare_output <= compare_output;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Pin override
   // ---------------------------------------------------------------
   assign pin_out = (|compare_output_mode) ? compare_output : port_latch;
   assign pin_oe  = compare_pin_direction;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_ovf_at_max: assert property (@(posedge clock) disable iff (!rstn)
      timer_tick && at_max && !counter_write |=> overflow_flag && counter_value == 8'h00)
      else $error("overflow flag not set on wrap to zero");

   a_ctc_clear: assert property (@(posedge clock) disable iff (!rstn)
      timer_tick && match && !counter_write && waveform_mode == tcw_pkg::WAVE_CLEAR
      |=> counter_value == 8'h00 && compare_flag)
      else $error("clear-on-match did not clear counter");

   a_ctc_toggle: assert property (@(posedge clock) disable iff (!rstn)
      timer_tick && match && waveform_mode == tcw_pkg::WAVE_CLEAR
      && compare_output_mode == tcw_pkg::OUT_TOGGLE |=> compare_output != $past(compare_output))
      else $error("toggle missing on match");

   a_write_priority: assert property (@(posedge clock) disable iff (!rstn)
      counter_write |=> counter_value == $past(counter_write_data))
      else $error("counter write lost to counting");

   a_match_blocked: assert property (@(posedge clock) disable iff (!rstn)
      counter_write ##1 (timer_tick && !counter_write && !compare_flag_clear && !compare_int_ack)
      |=> compare_flag == $past(compare_flag))
      else $error("match not blocked after counter write");

   a_force_no_flag: assert property (@(posedge clock) disable iff (!rstn)
      force_compare_strobe && !timer_tick && waveform_mode == tcw_pkg::WAVE_NORMAL
      && compare_output_mode == tcw_pkg::OUT_TOGGLE && !compare_flag_clear && !compare_int_ack
      |=> compare_output != $past(compare_output) && compare_flag == $past(compare_flag))
      else $error("forced compare misbehaved");

   a_pwm_bottom_set: assert property (@(posedge clock) disable iff (!rstn)
      wrap_pwm && compare_output_mode == tcw_pkg::OUT_CLEAR |=> compare_output)
      else $error("non-inverted PWM not set at bottom");

   a_pin_source: assert property (@(posedge clock) disable iff (!rstn)
      compare_output_mode != tcw_pkg::OUT_NONE |-> pin_out == compare_output)
      else $error("pin not driven by compare output");

   a_pwm_reload: assert property (@(posedge clock) disable iff (!rstn)
      wrap_pwm && !compare_write |=> compare_value == $past(compare_buffer))
      else $error("compare buffer not reloaded at top");

   a_tick_full: assert property (@(posedge clock) disable iff (!rstn)
      prescale_select == tcw_pkg::PRESC_1 && !counter_write
      && waveform_mode == tcw_pkg::WAVE_NORMAL |=> counter_value == $past(counter_value) + 8'h01)
      else $error("undivided tick did not count");

   a_reset_clears: assert property (@(posedge clock)
      !rstn ##1 !rstn |-> counter_value == tcw_pkg::COUNT_RESET && !compare_output
      && !overflow_flag && !compare_flag)
      else $error("reset did not clear the timer state");

   a_pin_latch: assert property (@(posedge clock) disable iff (!rstn)
      compare_output_mode == tcw_pkg::OUT_NONE |-> pin_out == port_latch)
      else $error("pin not driven by port latch");

   a_stop_holds: assert property (@(posedge clock) disable iff (!rstn)
      !timer_tick && !counter_write |=> counter_value == $past(counter_value))
      else $error("counter moved without a tick");

   a_pwm_wrap_zero: assert property (@(posedge clock) disable iff (!rstn)
      wrap_pwm |=> counter_value == tcw_pkg::COUNT_BOTTOM)
      else $error("fast PWM did not restart from bottom");

   a_pwm_match_clear: assert property (@(posedge clock) disable iff (!rstn)
      match_act && !wrap_pwm && waveform_mode == tcw_pkg::WAVE_FAST_PWM
      && compare_output_mode == tcw_pkg::OUT_CLEAR |=> !compare_output)
      else $error("non-inverted PWM not cleared on match");

   a_flag_set_wins: assert property (@(posedge clock) disable iff (!rstn)
      timer_tick && match |=> compare_flag)
      else $error("compare flag not set on match");

   a_ovf_cleared: assert property (@(posedge clock) disable iff (!rstn)
      (overflow_flag_clear || overflow_int_ack) && !(timer_tick && at_max && !counter_write)
      |=> !overflow_flag)
      else $error("overflow flag not cleared");

endmodule

// >>> tcw_load.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// External load on the compare pin
// ---------------------------------------------------------------
// A floating pin shows the inverse of its last level, so a stale
// value never passes for a driven one.
module tcw_load (
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic        pin_out,
   input  wire logic        pin_oe,
   output logic             pin_level,
   output logic [15:0]      rise_count
);
   logic last_level;

   assign pin_level = pin_oe ? pin_out : ~last_level;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         last_level <= 1'b0;
         rise_count <= 16'h0000;
      end else begin
         last_level <= pin_level;
         if (pin_oe && pin_level && !last_level) begin
            rise_count <= rise_count + 16'h0001;
         end
      end
   end
endmodule

// >>> tcw_timer8_bench.sv
`timescale 1ns/1ps
module tcw_timer8_bench;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic       clock, rstn, force_compare_strobe, counter_write, compare_write;
   logic [1:0] waveform_mode, compare_output_mode;
   logic [2:0] prescale_select;
   logic [7:0] counter_write_data, compare_write_data, counter_value, compare_value;
   logic [7:0] compare_buffer, m_cnt, m_cmp, m_buf;
   logic       overflow_flag_clear, overflow_int_ack, compare_flag_clear, compare_int_ack;
   logic       port_latch, compare_pin_direction, pin_out, pin_oe, compare_output;
   logic       overflow_flag, compare_flag, pin_level, m_oc, m_ovf, m_cf, m_blk;
   logic [9:0] m_presc;
   int         num_errors, n_checks, seed_v;

   tcw_timer8 #(.PRESC_WIDTH(10)) i_tcw_timer8 (.clock, .rstn, .waveform_mode,
      .compare_output_mode, .prescale_select, .force_compare_strobe, .counter_write,
      .counter_write_data, .compare_write, .compare_write_data, .overflow_flag_clear,
      .overflow_int_ack, .compare_flag_clear, .compare_int_ack, .port_latch,
      .compare_pin_direction, .pin_out, .pin_oe, .compare_output, .counter_value,
      .compare_value, .compare_buffer, .overflow_flag, .compare_flag);
   tcw_load i_tcw_load (.clock, .rstn, .pin_out, .pin_oe, .pin_level, .rise_count());

   initial clock = 1'b0;
   always #50 clock = ~clock;

   // ---------------------------------------------------------------
   // Reference model
   // ---------------------------------------------------------------
   function automatic logic tick_of(logic [2:0] s, logic [9:0] p);
      case (s)
         tcw_pkg::PRESC_1:    return 1'b1;
         tcw_pkg::PRESC_8:    return (p & tcw_pkg::MASK_8) == tcw_pkg::MASK_8;
         tcw_pkg::PRESC_64:   return (p & tcw_pkg::MASK_64) == tcw_pkg::MASK_64;
         tcw_pkg::PRESC_256:  return (p & tcw_pkg::MASK_256) == tcw_pkg::MASK_256;
         tcw_pkg::PRESC_1024: return p == tcw_pkg::MASK_1024;
         default:             return 1'b0;
      endcase
   endfunction

   function automatic logic act(logic [1:0] com, logic oc);
      case (com)
         tcw_pkg::OUT_TOGGLE: return ~oc;
         tcw_pkg::OUT_CLEAR:  return 1'b0;
         tcw_pkg::OUT_SET:    return 1'b1;
         default:             return oc;
      endcase
   endfunction

   always @(posedge clock or negedge rstn) begin : ref_model
      logic t, hit, fast, wrap;
      if (!rstn) begin
         {m_presc, m_cnt, m_cmp, m_buf} <= '0;
         {m_oc, m_ovf, m_cf, m_blk} <= '0;
      end else begin
         t = tick_of(prescale_select, m_presc);
         hit = t && !m_blk && m_cnt == m_cmp;
         fast = waveform_mode == tcw_pkg::WAVE_FAST_PWM;
         wrap = fast && t && !counter_write && m_cnt == 8'hFF;
         m_presc <= m_presc + 10'h001;
         if (compare_write) m_buf <= compare_write_data;
         if (compare_write && !waveform_mode[0]) m_cmp <= compare_write_data;
         if (wrap) m_cmp <= compare_write ? compare_write_data : m_buf;
         if (counter_write) m_cnt <= counter_write_data;
         else if (t) m_cnt <= (waveform_mode == tcw_pkg::WAVE_CLEAR && m_cnt == m_cmp)
            ? 8'h00 : m_cnt + 8'h01;
         m_blk <= counter_write ? 1'b1 : (t ? 1'b0 : m_blk);
         if (t && !counter_write && m_cnt == 8'hFF) m_ovf <= 1'b1;
         else if (overflow_flag_clear || overflow_int_ack) m_ovf <= 1'b0;
         if (hit) m_cf <= 1'b1;
         else if (compare_flag_clear || compare_int_ack) m_cf <= 1'b0;
         if (wrap && compare_output_mode[1])
            m_oc <= ~compare_output_mode[0];
         else if (waveform_mode != tcw_pkg::WAVE_PHASE_PWM
                  && (hit || (force_compare_strobe && !waveform_mode[0])))
            m_oc <= act(compare_output_mode, m_oc);
      end
   end

   // ---------------------------------------------------------------
   // Checking and driving
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic step();
      logic exp_pin;
      @(negedge clock);
      exp_pin = (compare_output_mode != 2'h0) ? m_oc : port_latch;
      check("counter", counter_value, m_cnt);
      check("compare", compare_value, m_cmp);
      check("buffer", compare_buffer, m_buf);
      check("output", compare_output, m_oc);
      check("overflow", overflow_flag, m_ovf);
      check("cmpflag", compare_flag, m_cf);
      check("pin", pin_out, exp_pin);
      check("pin_oe", pin_oe, compare_pin_direction);
      if (compare_pin_direction) check("level", pin_level, exp_pin);
      {counter_write, compare_write, force_compare_strobe} = '0;
      {overflow_flag_clear, overflow_int_ack, compare_flag_clear, compare_int_ack} = '0;
      port_latch = $urandom;
      compare_pin_direction = $urandom;
   endtask

   task automatic events(input logic [1:0] md);
      int r;
      r = $urandom % 48;
      case (r)
         0: {compare_write, compare_write_data} = {1'b1, 8'($urandom)};
         1: overflow_flag_clear = 1'b1;
         2: overflow_int_ack = 1'b1;
         3: compare_flag_clear = 1'b1;
         4: compare_int_ack = 1'b1;
         5: if (md == tcw_pkg::WAVE_NORMAL) {counter_write, counter_write_data} =
            {1'b1, 8'($urandom)};
         6: force_compare_strobe = !md[0] && m_cnt != m_cmp;
         default: ;
      endcase
   endtask

   task automatic run_phase(input logic [1:0] md, input logic [1:0] com,
                            input logic [2:0] ps, input logic [7:0] cv,
                            input logic [7:0] cn, input int len, input bit rnd);
      step();
      waveform_mode = tcw_pkg::WAVE_NORMAL;
      prescale_select = tcw_pkg::PRESC_1;
      compare_output_mode = com;
      {counter_write, counter_write_data, compare_write, compare_write_data} =
         {1'b1, cn, 1'b1, cv};
      step();
      step();
      waveform_mode = md;
      prescale_select = ps;
      repeat (len) begin
         step();
         if (rnd) events(md);
      end
   endtask

   task automatic final_report();
      $display("Checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      // Watchdog sized well above the planned run of about 8000 cycles
      #2000000;
      num_errors++;
      final_report();
   end

   initial begin
      logic [1:0] md, com;
      {waveform_mode, compare_output_mode, prescale_select} = '0;
      {force_compare_strobe, counter_write, compare_write, port_latch} = '0;
      {counter_write_data, compare_write_data, compare_pin_direction} = '0;
      {overflow_flag_clear, overflow_int_ack, compare_flag_clear, compare_int_ack} = '0;
      rstn = 1'b0;
      seed_v = $urandom(32'h6A2B6BFB);
      repeat (3) @(posedge clock);
      @(negedge clock) rstn = 1'b1;
      run_phase(2'h2, 2'h1, 3'h1, 8'h00, 8'hFE, 40, 1'b0);
      run_phase(2'h2, 2'h1, 3'h1, 8'h02, 8'h00, 40, 1'b0);
      run_phase(2'h0, 2'h3, 3'h1, 8'h10, 8'h10, 20, 1'b0);
      run_phase(2'h0, 2'h0, 3'h2, 8'h00, 8'hFE, 60, 1'b0);
      run_phase(2'h3, 2'h2, 3'h1, 8'h00, 8'hF0, 300, 1'b0);
      run_phase(2'h3, 2'h3, 3'h1, 8'hFF, 8'hF0, 300, 1'b0);
      run_phase(2'h3, 2'h1, 3'h1, 8'h10, 8'hF0, 300, 1'b1);
      @(negedge clock) rstn = 1'b0;
      repeat (2) step();
      rstn = 1'b1;
      run_phase(2'h2, 2'h2, 3'h1, 8'h05, 8'h20, 300, 1'b0);
      run_phase(2'h1, 2'h1, 3'h1, 8'h10, 8'h00, 300, 1'b1);
      run_phase(2'h0, 2'h1, 3'h2, 8'h40, 8'h00, 300, 1'b1);
      repeat (16) begin
         md = ($urandom % 3 == 0) ? 2'h0 : 2'($urandom % 2 + 2);
         com = 2'($urandom);
         if (md == tcw_pkg::WAVE_FAST_PWM && com == tcw_pkg::OUT_TOGGLE) com = 2'h2;
         run_phase(md, com, 3'($urandom), 8'($urandom), 8'($urandom), 400, 1'b1);
      end
      final_report();
   end
endmodule
